// ==== fpr_regs.sv ====
// Purpose: Protect decode, suspend/lock function register and read-parameter register pair of a serial flash
// Assumes: Instruction decode and array engine sit outside and drive one-cycle strobes
// Notes: Non-volatile copies are modelled in flops that reset to the factory default
`timescale 1ns/1ps
`include "fpr_consts.svh"

// How it works
// RULE1: Block-protect code maps to top or bottom 64 KB blocks, 0000/1111 none.
// RULE2: Codes 0101 through 1010 protect every block.
// RULE3: Suspend during program sets bit 2; resume clears it.
// RULE4: Suspend during erase sets bit 3; resume clears it.
// RULE5: Lock bits 4..7 reject programming of the matching information row.
// RULE6: Lock bits only ever go from zero to one.
// RULE7: Read and extended read registers are NV/volatile pairs; power-up copies NV.
// RULE8: In plain SPI with quad off, bit 7 picks hold (0) or reset (1).
// RULE9: Quad enable or four-wire mode ignores bit 7; pin is fourth data line.
// RULE10: Bits 6..3 give one to fifteen dummy cycles.
// RULE11: Bit 2 enables burst wrap, default off.
// RULE12: Bits 1..0 give burst of 8, 16, 32 or 64 bytes.
// RULE13: 65h writes NV copy, C0h/63h write volatile copy, only that copy.
// RULE14: Wrap disabled wraps over whole array; enabled wraps within burst.
// RULE15: Dummy field zero selects each command's own default count.
// RULE16: NV writes need the write enable latch; volatile writes do not.
// RULE17: Program or erase into a protected block is inhibited.
// RULE18: Function bits 1..0 read zero and ignore writes.
module fpr_regs
    import fpr_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic instr_valid_i,
    input wire logic [7:0] instr_code_i,
    input wire logic [7:0] instr_data_i,
    input wire logic write_enable_latch_i,
    input wire logic [3:0] block_protect_i,
    input wire logic quad_pins_enable_i,
    input wire logic four_wire_command_mode_i,
    input wire logic suspend_i,
    input wire logic resume_i,
    input wire logic program_busy_i,
    input wire logic erase_busy_i,
    input wire logic [7:0] read_cmd_i,
    input wire logic op_req_i,
    input wire logic op_is_row_i,
    input wire logic [3:0] op_block_i,
    input wire logic [1:0] op_row_i,
    output logic [7:0] func_reg_o,
    output logic [7:0] read_param_o,
    output logic [7:0] read_param_nv_o,
    output logic [7:0] ext_param_o,
    output logic [7:0] ext_param_nv_o,
    output logic [15:0] protected_blocks_o,
    output logic pin_is_reset_o,
    output logic pin_is_hold_o,
    output logic fourth_data_line_o,
    output logic [4:0] dummy_cycles_o,
    output logic wrap_in_burst_o,
    output logic [6:0] burst_bytes_o,
    output logic ready_o,
    output logic op_done_o,
    output logic op_inhibit_o
);
    // ****************************************
    // Decoding helpers
    // ****************************************
    function automatic logic [4:0] dummy_count(input logic [7:0] rp, input logic [7:0] cmd, input logic four_wire_command_mode);
        logic [3:0] fld;
        fld = rp[`FPR_RP_DUMMY_HI:`FPR_RP_DUMMY_LO];
        if (fld != 4'h0) begin
            dummy_count = {1'b0, fld}; // [RULE10]
        end else begin
            case (cmd) // [RULE15]
                `FPR_RD_FAST, `FPR_RD_FAST_DTR: dummy_count = four_wire_command_mode ? `FPR_DUMMY_DEF_6 : `FPR_DUMMY_DEF_8;
                `FPR_RD_DUAL_IO, `FPR_RD_DUAL_IO_DTR: dummy_count = `FPR_DUMMY_DEF_4;
                `FPR_RD_QUAD_IO, `FPR_RD_QUAD_IO_DTR: dummy_count = `FPR_DUMMY_DEF_6;
                default: dummy_count = `FPR_DUMMY_DEF_8;
            endcase
        end
    endfunction

    function automatic logic [6:0] burst_size(input logic [1:0] code);
        case (code) // [RULE12]
            2'h0: burst_size = `FPR_BURST_8;
            2'h1: burst_size = `FPR_BURST_16;
            2'h2: burst_size = `FPR_BURST_32;
            2'h3: burst_size = `FPR_BURST_64;
            default: burst_size = `FPR_BURST_8;
        endcase
    endfunction

    // ****************************************
    // Block protect decode
    // ****************************************
    logic [15:0] bp_mask;

    fpr_bp_decode u_bp_decode ( // [RULE1] [RULE2]
        .bp_i(block_protect_i),
        .mask_o(bp_mask)
    );

    // ****************************************
    // State update
    // ****************************************
    fpr_state_t s_q;
    fpr_state_t s_d;
    logic accept;
    logic quad_io;
    logic [7:0] rp_next;

    always_comb begin
        s_d = s_q;
        // Instructions are held off until the power-up copy is done
        accept = instr_valid_i && (s_q.pup == FPR_PUP_RUN);
        quad_io = quad_pins_enable_i || four_wire_command_mode_i;
        case (s_q.pup)
            FPR_PUP_LOAD: begin
                s_d.rp_v = s_q.rp_nv; // [RULE7]
                s_d.erp_v = s_q.erp_nv; // [RULE7]
                s_d.pup = FPR_PUP_RUN;
            end
            FPR_PUP_RUN: begin
                s_d.pup = FPR_PUP_RUN;
            end
            default: begin
                s_d.pup = FPR_PUP_LOAD;
            end
        endcase
        if (accept) begin
            case (instr_code_i)
                `FPR_OP_SRP_NV: begin
                    if (write_enable_latch_i) begin // [RULE16]
                        s_d.rp_nv = instr_data_i; // [RULE13]
                    end
                end
                `FPR_OP_SRP_V0, `FPR_OP_SRP_V1: begin
                    s_d.rp_v = instr_data_i; // [RULE13] [RULE16]
                end
                `FPR_OP_SERP_NV: begin
                    if (write_enable_latch_i) begin // [RULE16]
                        s_d.erp_nv = instr_data_i;
                    end
                end
                `FPR_OP_SERP_V: begin
                    s_d.erp_v = instr_data_i;
                end
                `FPR_OP_WR_FUNC: begin
                    // OTP: a one can be added, never removed; low bits dropped
                    if (write_enable_latch_i) begin // [RULE16]
                        s_d.row_lock = s_q.row_lock | instr_data_i[`FPR_FR_LOCK_HI:`FPR_FR_LOCK_LO]; // [RULE6] [RULE18]
                    end
                end
                default: begin
                    s_d.rp_v = s_d.rp_v;
                end
            endcase
        end
        // Resume clears, but a suspend in the same cycle wins
        if (resume_i && s_q.prog_susp) begin
            s_d.prog_susp = 1'b0; // [RULE3]
        end
        if (suspend_i && program_busy_i) begin
            s_d.prog_susp = 1'b1; // [RULE3]
        end
        if (resume_i && s_q.erase_susp) begin
            s_d.erase_susp = 1'b0; // [RULE4]
        end
        if (suspend_i && erase_busy_i) begin
            s_d.erase_susp = 1'b1; // [RULE4]
        end
        // Operation check against locks and protected region
        s_d.op_done = op_req_i;
        if (op_is_row_i) begin
            s_d.op_inhibit = op_req_i && s_q.row_lock[op_row_i]; // [RULE5]
        end else begin
            s_d.op_inhibit = op_req_i && bp_mask[op_block_i]; // [RULE17]
        end
        // Derived outputs are built from the next working copy, so they change on the same edge as it
        rp_next = s_d.rp_v;
        s_d.prot_mask = bp_mask;
        s_d.pin_data = quad_io; // [RULE9]
        s_d.pin_reset = !quad_io && rp_next[`FPR_RP_PIN_SEL]; // [RULE8]
        s_d.pin_hold = !quad_io && !rp_next[`FPR_RP_PIN_SEL]; // [RULE8]
        s_d.dummy = dummy_count(rp_next, read_cmd_i, four_wire_command_mode_i);
        s_d.wrap_in_burst = rp_next[`FPR_RP_WRAP_EN]; // [RULE11] [RULE14]
        s_d.burst_bytes = burst_size(rp_next[`FPR_RP_BURST_HI:`FPR_RP_BURST_LO]);
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q <= '0;
            s_q.pup <= FPR_PUP_LOAD;
            s_q.rp_nv <= `FPR_RP_RESET;
            s_q.rp_v <= `FPR_RP_RESET;
            s_q.erp_nv <= `FPR_ERP_RESET;
            s_q.erp_v <= `FPR_ERP_RESET;
            s_q.row_lock <= `FPR_FR_LOCK_RESET;
            s_q.pin_hold <= 1'b1;
            s_q.dummy <= `FPR_DUMMY_DEF_8;
            s_q.burst_bytes <= `FPR_BURST_8;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign func_reg_o = {s_q.row_lock, s_q.erase_susp, s_q.prog_susp, 2'b00}; // [RULE18]
    assign read_param_o = s_q.rp_v;
    assign read_param_nv_o = s_q.rp_nv;
    assign ext_param_o = s_q.erp_v;
    assign ext_param_nv_o = s_q.erp_nv;
    assign protected_blocks_o = s_q.prot_mask;
    assign pin_is_reset_o = s_q.pin_reset;
    assign pin_is_hold_o = s_q.pin_hold;
    assign fourth_data_line_o = s_q.pin_data;
    assign dummy_cycles_o = s_q.dummy;
    assign wrap_in_burst_o = s_q.wrap_in_burst;
    assign burst_bytes_o = s_q.burst_bytes;
    assign ready_o = (s_q.pup == FPR_PUP_RUN);
    assign op_done_o = s_q.op_done;
    assign op_inhibit_o = s_q.op_inhibit;
endmodule

// ==== fpr_consts.svh ====
// Purpose: Offsets, field positions, reset values and instruction codes for the flash protect/read config block
// Assumes: Included by bare name from package and modules
// Notes: Definitions only
`ifndef FPR_CONSTS_SVH
`define FPR_CONSTS_SVH

// ****************************************
// Instruction codes
// ****************************************
`define FPR_OP_SRP_NV 8'h65
`define FPR_OP_SRP_V0 8'hC0
`define FPR_OP_SRP_V1 8'h63
`define FPR_OP_SERP_NV 8'h85
// Volatile extended set code; value is a plain choice
`define FPR_OP_SERP_V 8'h83
`define FPR_OP_WR_FUNC 8'h42

// ****************************************
// Read commands for dummy defaults
// ****************************************
`define FPR_RD_FAST 8'h0B
`define FPR_RD_FAST_DTR 8'h0D
`define FPR_RD_DUAL_OUT 8'h3B
`define FPR_RD_DUAL_IO 8'hBB
`define FPR_RD_DUAL_IO_DTR 8'hBD
`define FPR_RD_QUAD_OUT 8'h6B
`define FPR_RD_QUAD_IO 8'hEB
`define FPR_RD_QUAD_IO_DTR 8'hED
`define FPR_DUMMY_DEF_8 5'h08
`define FPR_DUMMY_DEF_6 5'h06
`define FPR_DUMMY_DEF_4 5'h04

// ****************************************
// Read parameter fields
// ****************************************
`define FPR_RP_PIN_SEL 7
`define FPR_RP_DUMMY_HI 6
`define FPR_RP_DUMMY_LO 3
`define FPR_RP_WRAP_EN 2
`define FPR_RP_BURST_HI 1
`define FPR_RP_BURST_LO 0
`define FPR_RP_RESET 8'h00
`define FPR_ERP_RESET 8'h00

// ****************************************
// Function register fields
// ****************************************
`define FPR_FR_PROGRAM_SUSPENDED_FLAG 2
`define FPR_FR_ERASE_SUSPENDED_FLAG 3
`define FPR_FR_LOCK_LO 4
`define FPR_FR_LOCK_HI 7
`define FPR_FR_LOCK_RESET 4'h0

// ****************************************
// Burst sizes in bytes
// ****************************************
`define FPR_BURST_8 7'h08
`define FPR_BURST_16 7'h10
`define FPR_BURST_32 7'h20
`define FPR_BURST_64 7'h40

`endif

// ==== fpr_pkg.sv ====
// Purpose: Types for the flash protect/read config block
// Assumes: fpr_consts.svh holds the numbers
// Notes: State of the top module is one packed struct
package fpr_pkg;
    `include "fpr_consts.svh"

    typedef enum logic [0:0] {
        FPR_PUP_LOAD = 1'b0,
        FPR_PUP_RUN = 1'b1
    } fpr_pup_t;

    typedef struct packed {
        fpr_pup_t pup;
        logic [7:0] rp_nv;
        logic [7:0] rp_v;
        logic [7:0] erp_nv;
        logic [7:0] erp_v;
        logic [3:0] row_lock;
        logic prog_susp;
        logic erase_susp;
        logic [15:0] prot_mask;
        logic pin_reset;
        logic pin_hold;
        logic pin_data;
        logic [4:0] dummy;
        logic wrap_in_burst;
        logic [6:0] burst_bytes;
        logic op_done;
        logic op_inhibit;
    } fpr_state_t;
endpackage

// ==== fpr_bp_decode.sv ====
// Purpose: Map four block-protect bits to a 16-block protection mask
// Assumes: Largest density, sixteen 64 KB blocks
// Notes: Purely combinational
`timescale 1ns/1ps
module fpr_bp_decode
    import fpr_pkg::*;
(
    input wire logic [3:0] bp_i,
    output logic [15:0] mask_o
);
    always_comb begin
        case (bp_i)
            4'h0: mask_o = 16'h0000; // [RULE1]
            4'h1: mask_o = 16'h8000; // [RULE1]
            4'h2: mask_o = 16'hC000; // [RULE1]
            4'h3: mask_o = 16'hF000; // [RULE1]
            4'h4: mask_o = 16'hFF00; // [RULE1]
            4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA: mask_o = 16'hFFFF; // [RULE2]
            4'hB: mask_o = 16'h00FF; // [RULE1]
            4'hC: mask_o = 16'h000F; // [RULE1]
            4'hD: mask_o = 16'h0003; // [RULE1]
            4'hE: mask_o = 16'h0001; // [RULE1]
            4'hF: mask_o = 16'h0000; // [RULE1]
            default: mask_o = 16'h0000;
        endcase
    end
endmodule

// ==== fpr_regs_properties.sv ====
// Purpose: Port-level temporal checks for fpr_regs
// Assumes: Strobes are driven just after the rising edge
// Notes: Bound to the design below the module
`timescale 1ns/1ps
module fpr_regs_properties (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic instr_valid_i,
    input wire logic [7:0] instr_code_i,
    input wire logic [7:0] instr_data_i,
    input wire logic write_enable_latch_i,
    input wire logic suspend_i,
    input wire logic resume_i,
    input wire logic program_busy_i,
    input wire logic erase_busy_i,
    input wire logic op_req_i,
    input wire logic op_is_row_i,
    input wire logic [3:0] op_block_i,
    input wire logic [1:0] op_row_i,
    input wire logic [7:0] func_reg_o,
    input wire logic [7:0] read_param_o,
    input wire logic [7:0] read_param_nv_o,
    input wire logic [15:0] protected_blocks_o,
    input wire logic ready_o,
    input wire logic op_done_o,
    input wire logic op_inhibit_o
);
    // ****************
    // Checks
    // ****************
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);
    logic lock_hit;
    // Lock bits sit at 4..7, so the row index picks bit {1,row}
    assign lock_hit = func_reg_o[{1'h1, op_row_i}];
    sequence s_wr(c);
        instr_valid_i && ready_o && instr_code_i == c;
    endsequence
    a_prog_susp_set: assert property (suspend_i && program_busy_i |=> func_reg_o[2])
        else $error("program suspend flag not set");
    a_erase_susp_set: assert property (suspend_i && erase_busy_i |=> func_reg_o[3])
        else $error("erase suspend flag not set");
    a_resume_clear: assert property (resume_i && !suspend_i |=> func_reg_o[3:2] == 2'h0)
        else $error("suspend flag not cleared");
    a_lock_sticky: assert property (ready_o |=> (func_reg_o[7:4] & $past(func_reg_o[7:4])) == $past(func_reg_o[7:4]))
        else $error("row lock cleared");
    a_rsvd_zero: assert property (func_reg_o[1:0] == 2'h0) else $error("reserved bits set");
    a_op_pulse: assert property (ready_o |=> op_done_o == $past(op_req_i)) else $error("op done timing");
    a_row_inhibit: assert property (op_req_i && op_is_row_i |=> op_inhibit_o == $past(lock_hit))
        else $error("row lock not honoured");
    // The mask shown one cycle after the request is the live decode the check used
    a_blk_inhibit: assert property (op_req_i && !op_is_row_i |=>
        op_inhibit_o == protected_blocks_o[$past(op_block_i)]) else $error("block protect not honoured");
    a_vol_write: assert property ((s_wr(8'hC0) or s_wr(8'h63)) |=>
        read_param_o == $past(instr_data_i) && $stable(read_param_nv_o)) else $error("working copy write");
    a_nv_write: assert property (s_wr(8'h65) ##0 write_enable_latch_i |=>
        read_param_nv_o == $past(instr_data_i) && $stable(read_param_o)) else $error("persistent copy write");
endmodule

bind fpr_regs fpr_regs_properties i_fpr_regs_properties (.ref_clk_i, .nrst_i, .instr_valid_i, .instr_code_i,
    .instr_data_i, .write_enable_latch_i, .suspend_i, .resume_i, .program_busy_i, .erase_busy_i, .op_req_i,
    .op_is_row_i,
    .op_block_i, .op_row_i, .func_reg_o, .read_param_o, .read_param_nv_o, .protected_blocks_o, .ready_o,
    .op_done_o, .op_inhibit_o);

// ==== fpr_host_model.sv ====
// Purpose: Host controller stand-in on the instruction port
// Assumes: send is entered 10 ns after a rising edge
// Notes: Released lines show the inverse byte
`timescale 1ns/1ps
module fpr_host_model (
    input wire logic clk_i,
    output logic instr_valid_o,
    output logic [7:0] instr_code_o,
    output logic [7:0] instr_data_o,
    output logic wel_o
);
    initial begin
        {instr_valid_o, instr_code_o, instr_data_o, wel_o} = '0;
    end
    // One byte per instruction; latch set only where asked
    task automatic send(input logic [7:0] c, input logic [7:0] d, input logic w);
        instr_valid_o = 1'h1;
        instr_code_o = c;
        instr_data_o = d;
        wel_o = w;
        @(posedge clk_i);
        #10;
        // Stale bytes would hide a late sample
        {instr_valid_o, wel_o} = '0;
        instr_code_o = ~c;
        instr_data_o = ~d;
        @(posedge clk_i);
        #10;
    endtask
endmodule

// ==== flash_protect_and_read_config_regs_tb.sv ====
// Purpose: Self-checking bench for fpr_regs
// Assumes: Inputs change 10 ns after each rising edge
// Notes: Host model drives the instruction port
`timescale 1ns/1ps
module flash_protect_and_read_config_regs_tb;
    logic clk, nrst, vld, write_enable_latch, quad, fw, sus, rsm, pb, eb, req, isr, rdy, done, inh, prst, phold, d4, wrap;
    logic [7:0] code, data, rcmd, func, rp, rpnv, ep, epnv;
    logic [3:0] bp, blk;
    logic [1:0] row;
    logic [15:0] prot;
    logic [4:0] dum;
    logic [6:0] burst;
    int num_errors = 0;
    int comparisons = 0;
    logic [15:0] masks [16] = '{16'h0000, 16'h8000, 16'hC000, 16'hF000, 16'hFF00, 16'hFFFF, 16'hFFFF, 16'hFFFF,
        16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF, 16'h000F, 16'h0003, 16'h0001, 16'h0000};
    fpr_regs i_fpr_regs (.ref_clk_i(clk), .nrst_i(nrst), .instr_valid_i(vld), .instr_code_i(code),
        .instr_data_i(data), .write_enable_latch_i(write_enable_latch), .block_protect_i(bp), .quad_pins_enable_i(quad),
        .four_wire_command_mode_i(fw), .suspend_i(sus), .resume_i(rsm), .program_busy_i(pb), .erase_busy_i(eb),
        .read_cmd_i(rcmd), .op_req_i(req), .op_is_row_i(isr), .op_block_i(blk), .op_row_i(row),
        .func_reg_o(func), .read_param_o(rp), .read_param_nv_o(rpnv), .ext_param_o(ep), .ext_param_nv_o(epnv),
        .protected_blocks_o(prot), .pin_is_reset_o(prst), .pin_is_hold_o(phold), .fourth_data_line_o(d4),
        .dummy_cycles_o(dum), .wrap_in_burst_o(wrap), .burst_bytes_o(burst), .ready_o(rdy), .op_done_o(done),
        .op_inhibit_o(inh));
    fpr_host_model i_fpr_host_model (.clk_i(clk), .instr_valid_o(vld), .instr_code_o(code), .instr_data_o(data),
        .wel_o(write_enable_latch));
    // ****************
    // Tasks
    // ****************
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic w);
        i_fpr_host_model.send(c, d, w);
    endtask
    task automatic op(input logic r, input logic [1:0] w, input logic [3:0] b, input logic e);
        req = 1'h1;
        isr = r;
        row = w;
        blk = b;
        step(1);
        req = 1'h0;
        chk("op_done", done, 1'h1);
        chk("op_inhibit", inh, e);
        step(1);
    endtask
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end
    // Whole run is under two hundred cycles
    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        final_report();
    end
    initial begin
        {nrst, quad, fw, sus, rsm, pb, eb, req, isr, bp, blk, row} = '0;
        rcmd = 8'h0B;
        step(2);
        nrst = 1'h1;
        for (int k = 0; k < 8 && rdy !== 1'h1; k++)
            step(1);
        step(1);
        chk("rp", rp, 8'h00);
        chk("erp", ep, 8'h00);
        chk("hold", phold, 1'h1);
        chk("dummy", dum, 5'h08);
        $display("test power_up done");
        for (int i = 0; i < 16; i++) begin
            bp = i[3:0];
            step(2);
            chk("mask", prot, masks[i]);
            op(1'h0, 2'h0, 4'hF, masks[i][15]);
            op(1'h0, 2'h0, 4'h0, masks[i][0]);
        end
        $display("test protect done");
        for (int i = 0; i < 4; i++) begin
            wr(i[0] ? 8'h63 : 8'hC0, 8'h84 | i[7:0], 1'h0);
            chk("rp", rp, 8'h84 | i[7:0]);
            chk("burst", burst, 7'h08 << i);
            chk("wrap", wrap, 1'h1);
            chk("reset_sel", prst, 1'h1);
        end
        rcmd = 8'hBB;
        quad = 1'h1;
        step(2);
        chk("dummy", dum, 5'h04);
        chk("data_line", d4, 1'h1);
        chk("reset_sel", prst, 1'h0);
        chk("hold", phold, 1'h0);
        {quad, fw} = 2'h1;
        rcmd = 8'h0B;
        step(2);
        chk("dummy", dum, 5'h06);
        chk("data_line", d4, 1'h1);
        fw = 1'h0;
        wr(8'hC0, 8'hF8, 1'h0);
        chk("data_line", d4, 1'h0);
        chk("dummy", dum, 5'h0F);
        chk("wrap", wrap, 1'h0);
        wr(8'h65, 8'hA5, 1'h0);
        chk("rp_nv", rpnv, 8'h00);
        wr(8'h65, 8'hA5, 1'h1);
        chk("rp_nv", rpnv, 8'hA5);
        wr(8'h83, 8'h3C, 1'h0);
        chk("erp", ep, 8'h3C);
        wr(8'h85, 8'hC3, 1'h1);
        chk("erp_nv", epnv, 8'hC3);
        chk("erp", ep, 8'h3C);
        $display("test read_param done");
        op(1'h1, 2'h0, 4'h0, 1'h0);
        wr(8'h42, 8'h5F, 1'h1);
        chk("func", func, 8'h50);
        wr(8'h42, 8'h00, 1'h1);
        chk("func", func, 8'h50);
        wr(8'h42, 8'hA0, 1'h0);
        chk("func", func, 8'h50);
        op(1'h1, 2'h0, 4'h0, 1'h1);
        op(1'h1, 2'h1, 4'h0, 1'h0);
        wr(8'h42, 8'hA0, 1'h1);
        chk("func", func, 8'hF0);
        op(1'h1, 2'h3, 4'h0, 1'h1);
        $display("test row_lock done");
        {pb, sus} = 2'h3;
        step(1);
        chk("func", func, 8'hF4);
        {rsm, pb, sus} = 3'h7;
        step(1);
        chk("func", func, 8'hF4);
        {rsm, pb, sus} = 3'h4;
        step(1);
        chk("func", func, 8'hF0);
        {rsm, eb, sus} = 3'h3;
        step(1);
        chk("func", func, 8'hF8);
        {rsm, eb, sus} = 3'h4;
        step(1);
        chk("func", func, 8'hF0);
        {rsm, sus} = 2'h1;
        step(1);
        sus = 1'h0;
        chk("func", func, 8'hF0);
        $display("test suspend done");
        final_report();
    end
endmodule
